/* File: common/acs_defines.vh */
// constants for the converter conversion sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// -----------------------------------------------------------------
// register addresses and reset values
// -----------------------------------------------------------------
`define ACS_ADDR_W             20
`define ACS_REF_OPT_ADDR       20'hF0010
`define ACS_TRIG_MODE_ADDR     20'hFFF32
`define ACS_REF_OPT_RST        8'h00
`define ACS_TRIG_MODE_RST      8'h00
`define ACS_REF_OPT_MASK       8'hED
`define ACS_TRIG_MODE_MASK     8'hE3

// -----------------------------------------------------------------
// trigger/mode register fields
// -----------------------------------------------------------------
`define ACS_TM_TMODE_HI        7
`define ACS_TM_TMODE_LO        6
`define ACS_TM_ONESHOT         5
`define ACS_TM_TSRC_HI         1
`define ACS_TM_TSRC_LO         0

// -----------------------------------------------------------------
// reference/option register fields
// -----------------------------------------------------------------
`define ACS_RO_PREF_HI         7
`define ACS_RO_PREF_LO         6
`define ACS_RO_NREF            5
`define ACS_RO_RANGE           3
`define ACS_RO_WAKE            2
`define ACS_RO_RES             0

// -----------------------------------------------------------------
// codes
// -----------------------------------------------------------------
`define ACS_TSRC_TIMER         2'h0
`define ACS_TSRC_EVENT         2'h1
`define ACS_TSRC_INTERVAL      2'h3
`define ACS_PREF_SUPPLY        2'h0
`define ACS_PREF_EXTPIN        2'h1
`define ACS_PREF_INTERNAL      2'h2

// -----------------------------------------------------------------
// timing counts, in converter clocks unless noted
// -----------------------------------------------------------------
`define ACS_STAB_NORMAL        5'd8
`define ACS_STAB_LOWV          5'd2
`define ACS_CONV_MODE1         5'd19
`define ACS_CONV_MODE2         5'd17
`define ACS_CONV_8BIT_LESS     5'd2
`define ACS_FIRST_EXTRA        5'd1
`define ACS_IT_GUARD_FCLK      3'd4
`define ACS_SCAN_LAST          2'h3

`endif

/* File: hw/acs_clkdiv.v */
// converter clock enable divider
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_clkdiv (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // control
    input  wire       clr_i,
    input  wire [2:0] sel_i,
    // one-cycle converter clock enable
    output wire       tick_o
);

    reg  [5:0] cnt_q;
    reg  [5:0] last;

    // -----------------------------------------------------------------
    // divide select decode
    // -----------------------------------------------------------------
    always @* begin
        case (sel_i)
            3'h0:    last = 6'd63;
            3'h1:    last = 6'd31;
            3'h2:    last = 6'd15;
            3'h3:    last = 6'd7;
            3'h4:    last = 6'd5;
            3'h5:    last = 6'd4;
            3'h6:    last = 6'd3;
            default: last = 6'd1;
        endcase
    end

    // cleared on start so the first tick lands a full period later
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 6'h00;
        end else if (clr_i || cnt_q >= last) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_q + 6'd1;
        end
    end

    assign tick_o = !clr_i && (cnt_q >= last);

endmodule

/* File: hw/acs_sequencer.v */
// conversion sequencer: mode registers, triggers, timing phases
// How it works
// - converter clock is fclk over 64..2; 19 or 17 clocks, two fewer at 8-bit.
// - hardware wait mode adds 8 or 2 converter clocks of supply settling.
// - later sequential and scan 1-3 conversions skip start delay and settling.
// - wait-mode total is divider times settling, one extra and conversion clocks.
// - first conversion alone gets an extra conversion-state interval.
// - mode field 7:6: 00/01 software, 10 hardware no-wait, 11 hardware wait.
// - bit 5 low repeats conversions, high converts once.
// - source 00 timer channel 1, 01 event link, 11 interval timer, 10 banned.
// - outside wake mode, a second interval trigger within four fclk is ignored.
// - reset clears both mode registers to zero.
// - positive reference 00 supply, 01 external pin, 10 internal 1.45 V.
// - in wait mode a hardware trigger sets the run flag; software only clears it.
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer (
    // clock and reset
    input  wire                   CLK_I,
    input  wire                   RST_N_I,
    // register access
    input  wire [`ACS_ADDR_W-1:0] ADDR_I,
    input  wire [7:0]             WDATA_I,
    input  wire                   WE_I,
    output reg  [7:0]             RDATA_O,
    // loose control bits
    input  wire [2:0]             CLK_DIV_SEL_I,
    input  wire [1:0]             TIMING_MODE_SEL_I,
    input  wire                   CONVERTER_ENABLE_I,
    input  wire                   SCAN_MODE_I,
    input  wire                   RUN_SET_I,
    input  wire                   RUN_CLR_I,
    // hardware trigger sources
    input  wire                   TIMER_CH1_IRQ_I,
    input  wire                   EVENT_LINK_I,
    input  wire                   INTERVAL_TIMER_IRQ_I,
    // status and analog control
    output wire                   CONV_RUN_FLAG_O,
    output wire                   STAB_WAIT_O,
    output wire                   CONVERTING_O,
    output reg                    CONV_DONE_O,
    output wire [1:0]             SCAN_POS_O,
    output wire [1:0]             POS_REF_SEL_O,
    output wire                   NEG_REF_SEL_O,
    output wire                   RANGE_CHECK_SEL_O,
    output wire                   WAKE_CONVERT_ENABLE_O,
    output wire                   RESOLUTION_SEL_O
);

    localparam [4:0] S_IDLE  = 5'b00001;
    localparam [4:0] S_START = 5'b00010;
    localparam [4:0] S_STAB  = 5'b00100;
    localparam [4:0] S_FIRST = 5'b01000;
    localparam [4:0] S_CONV  = 5'b10000;

    // -----------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------
    reg        rst_s1_q;
    reg        rst_n;
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // -----------------------------------------------------------------
    // mode registers
    // -----------------------------------------------------------------
    reg  [7:0] trig_mode_q;
    reg  [7:0] ref_opt_q;
    wire       sel_tm = (ADDR_I == `ACS_TRIG_MODE_ADDR);
    wire       sel_ro = (ADDR_I == `ACS_REF_OPT_ADDR);

    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            trig_mode_q <= `ACS_TRIG_MODE_RST;
            ref_opt_q   <= `ACS_REF_OPT_RST;
        end else if (WE_I) begin
            if (sel_tm) begin
                trig_mode_q <= WDATA_I & `ACS_TRIG_MODE_MASK;
            end
            if (sel_ro) begin
                ref_opt_q <= WDATA_I & `ACS_REF_OPT_MASK;
            end
        end
    end

    // unmapped addresses read zero
    always @* begin
        if (sel_tm) begin
            RDATA_O = trig_mode_q;
        end else if (sel_ro) begin
            RDATA_O = ref_opt_q;
        end else begin
            RDATA_O = 8'h00;
        end
    end

    wire [1:0] tmode    = trig_mode_q[`ACS_TM_TMODE_HI:`ACS_TM_TMODE_LO];
    wire       hw_mode  = tmode[1];
    wire       hw_wait  = tmode[1] & tmode[0];
    wire       hw_nowt  = tmode[1] & ~tmode[0];
    wire       oneshot  = trig_mode_q[`ACS_TM_ONESHOT];
    wire [1:0] tsrc     = trig_mode_q[`ACS_TM_TSRC_HI:`ACS_TM_TSRC_LO];
    wire       wake_en  = ref_opt_q[`ACS_RO_WAKE];
    wire       res_8bit = ref_opt_q[`ACS_RO_RES];

    // reference select straight to the analog side
    assign POS_REF_SEL_O         = ref_opt_q[`ACS_RO_PREF_HI:`ACS_RO_PREF_LO];
    assign NEG_REF_SEL_O         = ref_opt_q[`ACS_RO_NREF];
    assign RANGE_CHECK_SEL_O     = ref_opt_q[`ACS_RO_RANGE];
    assign WAKE_CONVERT_ENABLE_O = wake_en;
    assign RESOLUTION_SEL_O      = res_8bit;

    // -----------------------------------------------------------------
    // hardware trigger selection and interval guard
    // -----------------------------------------------------------------
    reg  [2:0] it_guard_q;
    reg        hw_raw;

    // source select, prohibited code never triggers
    always @* begin
        case (tsrc)
            `ACS_TSRC_TIMER:    hw_raw = TIMER_CH1_IRQ_I;
            `ACS_TSRC_EVENT:    hw_raw = EVENT_LINK_I;
            `ACS_TSRC_INTERVAL: hw_raw = INTERVAL_TIMER_IRQ_I && (it_guard_q == 3'd0);
            default:            hw_raw = 1'b0;
        endcase
    end

    wire hw_trig = hw_mode && CONVERTER_ENABLE_I && hw_raw;

    // mask repeat interval triggers for four fclk
    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            it_guard_q <= 3'd0;
        end else if (hw_trig && tsrc == `ACS_TSRC_INTERVAL && !wake_en) begin
            it_guard_q <= `ACS_IT_GUARD_FCLK;
        end else if (it_guard_q != 3'd0) begin
            it_guard_q <= it_guard_q - 3'd1;
        end
    end

    // -----------------------------------------------------------------
    // converter clock and phase lengths
    // -----------------------------------------------------------------
    reg  [4:0] state_q;
    reg  [4:0] state_d;
    reg  [4:0] cnt_q;
    reg  [1:0] scan_q;
    reg        first_q;
    reg        run_q;
    wire       fad_tick;
    wire       div_clr = (state_q == S_IDLE);

    acs_clkdiv u_div (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .clr_i   (div_clr),
        .sel_i   (CLK_DIV_SEL_I),
        .tick_o  (fad_tick)
    );

    wire [4:0] stab_len = TIMING_MODE_SEL_I[1] ? `ACS_STAB_LOWV : `ACS_STAB_NORMAL;
    wire [4:0] conv_base = TIMING_MODE_SEL_I[0] ? `ACS_CONV_MODE2 : `ACS_CONV_MODE1;
    wire [4:0] conv_len  = res_8bit ? (conv_base - `ACS_CONV_8BIT_LESS) : conv_base;
    // phases advance on converter clock ticks only
    wire       last_tick = fad_tick && (cnt_q == 5'd1);

    // -----------------------------------------------------------------
    // sequencing
    // -----------------------------------------------------------------
    // software trigger mode starts on the run flag; hardware modes on a trigger
    wire sw_go    = !hw_mode && run_q && CONVERTER_ENABLE_I;
    wire nowt_go  = hw_nowt && run_q && hw_trig;
    wire wait_go  = hw_wait && hw_trig;
    wire conv_end = (state_q == S_CONV) && last_tick;
    wire more_scan = SCAN_MODE_I && (scan_q != `ACS_SCAN_LAST);
    wire continue_seq = more_scan || !oneshot;
    wire run_stop = !run_q || !CONVERTER_ENABLE_I;

    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (wait_go) begin
                    state_d = S_STAB;
                end else if (sw_go || nowt_go) begin
                    state_d = S_START;
                end
            end
            S_START: begin
                if (fad_tick) begin
                    state_d = first_q ? S_FIRST : S_CONV;
                end
            end
            S_STAB: begin
                if (last_tick) begin
                    state_d = first_q ? S_FIRST : S_CONV;
                end
            end
            S_FIRST: begin
                if (last_tick) begin
                    state_d = S_CONV;
                end
            end
            S_CONV: begin
                // follow-on conversions go straight to converting
                if (last_tick && !continue_seq) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (run_stop && state_q != S_IDLE && !wait_go) begin
            state_d = S_IDLE;
        end
    end

    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            cnt_q       <= 5'd0;
            scan_q      <= 2'h0;
            first_q     <= 1'b1;
            CONV_DONE_O <= 1'b0;
        end else begin
            state_q     <= state_d;
            CONV_DONE_O <= conv_end;
            if (state_d == S_IDLE) begin
                first_q <= 1'b1;
                scan_q  <= 2'h0;
            end else if (conv_end) begin
                first_q <= 1'b0;
                scan_q  <= more_scan ? scan_q + 2'h1 : 2'h0;
            end
            // settling then conversion, back to back in ticks
            if (state_d == S_STAB && state_q != S_STAB) begin
                cnt_q <= stab_len;
            // extra interval before the first conversion
            end else if (state_d == S_FIRST && state_q != S_FIRST) begin
                cnt_q <= `ACS_FIRST_EXTRA;
            end else if (state_d == S_CONV && (state_q != S_CONV || conv_end)) begin
                cnt_q <= conv_len;
            end else if (fad_tick && cnt_q != 5'd0) begin
                cnt_q <= cnt_q - 5'd1;
            end
        end
    end

    // -----------------------------------------------------------------
    // run flag
    // -----------------------------------------------------------------
    // one-shot ends clear it except in no-wait mode, which keeps it set
    wire auto_clr = conv_end && !continue_seq && !hw_nowt;

    // trigger sets it in wait mode; software set refused there
    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (wait_go || (RUN_SET_I && !hw_wait)) begin
            run_q <= 1'b1;
        end else if (RUN_CLR_I || auto_clr) begin
            run_q <= 1'b0;
        end
    end

    assign CONV_RUN_FLAG_O = run_q;
    assign STAB_WAIT_O     = (state_q == S_STAB);
    assign CONVERTING_O    = (state_q == S_FIRST) || (state_q == S_CONV);
    assign SCAN_POS_O      = scan_q;

endmodule

/* File: dv/acs_sequencer_asserts.sv */
// port-level checks for the conversion sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer_asserts (
    // clock, reset, register writes
    input wire                   CLK_I,
    input wire                   RST_N_I,
    input wire [`ACS_ADDR_W-1:0] ADDR_I,
    input wire [7:0]             WDATA_I,
    input wire                   WE_I,
    // loose bits and triggers
    input wire [2:0]             CLK_DIV_SEL_I,
    input wire [1:0]             TIMING_MODE_SEL_I,
    input wire                   CONVERTER_ENABLE_I,
    input wire                   SCAN_MODE_I,
    input wire                   RUN_SET_I,
    input wire                   RUN_CLR_I,
    input wire                   TIMER_CH1_IRQ_I,
    input wire                   EVENT_LINK_I,
    input wire                   INTERVAL_TIMER_IRQ_I,
    // watched outputs
    input wire                   CONV_RUN_FLAG_O,
    input wire                   STAB_WAIT_O,
    input wire                   CONVERTING_O,
    input wire                   CONV_DONE_O,
    input wire [1:0]             POS_REF_SEL_O,
    input wire                   RESOLUTION_SEL_O
);
    // shadow of mode writes; settle length counted in fclk, not ticks
    reg  [7:0] tm_q;
    reg        rst_seen_q;
    reg  [9:0] scnt_q;
    wire       trig_any = TIMER_CH1_IRQ_I | EVENT_LINK_I | INTERVAL_TIMER_IRQ_I;
    wire [6:0] n_div = (CLK_DIV_SEL_I == 3'h7) ? 7'h02 :
                       CLK_DIV_SEL_I[2] ? 7'h0A - {4'h0, CLK_DIV_SEL_I} : 7'h40 >> CLK_DIV_SEL_I;
    wire [9:0] stab_len = {3'h0, n_div} * (TIMING_MODE_SEL_I[1] ? 10'h002 : 10'h008);

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tm_q   <= 8'h00;
            scnt_q <= 10'h000;
        end else begin
            if (WE_I && ADDR_I == `ACS_TRIG_MODE_ADDR)
                tm_q <= WDATA_I & `ACS_TRIG_MODE_MASK;
            scnt_q <= STAB_WAIT_O ? scnt_q + 10'h001 : 10'h000;
        end
    end

    // reset seen one edge earlier, so the check waits for the async clear
    always @(posedge CLK_I) begin
        rst_seen_q <= !RST_N_I;
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence stab_end_s;
        $fell(STAB_WAIT_O) && CONVERTING_O;
    endsequence
    sequence seq_done_s;
        CONV_DONE_O && !tm_q[5] && !tm_q[7] && CONV_RUN_FLAG_O && CONVERTER_ENABLE_I && !RUN_CLR_I;
    endsequence

    reset_clear_a: assert property (disable iff (1'b0)
        !RST_N_I && rst_seen_q |-> POS_REF_SEL_O == 2'h0 && !CONV_RUN_FLAG_O && !STAB_WAIT_O)
        else $error("outputs not clear in reset");
    ref_write_a: assert property (WE_I && ADDR_I == `ACS_REF_OPT_ADDR |=>
        POS_REF_SEL_O == $past(WDATA_I[7:6]) && RESOLUTION_SEL_O == $past(WDATA_I[0]))
        else $error("reference fields not loaded");
    stab_mode_a: assert property (STAB_WAIT_O |-> tm_q[7:6] == 2'b11)
        else $error("settling outside wait mode");
    stab_len_a: assert property (stab_end_s |-> scnt_q == stab_len)
        else $error("settling length wrong");
    run_hw_set_a: assert property ($rose(STAB_WAIT_O) |-> CONV_RUN_FLAG_O)
        else $error("trigger did not set run flag");
    run_sw_block_a: assert property (tm_q[7:6] == 2'b11 && !CONV_RUN_FLAG_O && RUN_SET_I && !trig_any
        |=> !CONV_RUN_FLAG_O)
        else $error("software set run in wait mode");
    sw_start_a: assert property ($rose(CONV_RUN_FLAG_O) && !tm_q[7] && CONVERTER_ENABLE_I
        |-> ##[1:65] CONVERTING_O)
        else $error("software start missing");
    oneshot_stop_a: assert property (CONV_DONE_O && tm_q[5] && tm_q[7:6] != 2'b10 && !SCAN_MODE_I
        |=> !CONV_RUN_FLAG_O)
        else $error("one-shot did not stop");
    seq_direct_a: assert property (seq_done_s |-> CONVERTING_O && !STAB_WAIT_O)
        else $error("sequential restart not direct");
    src_banned_a: assert property (tm_q[7:6] == 2'b11 && tm_q[1:0] == 2'h2 |-> !STAB_WAIT_O)
        else $error("banned source triggered");
endmodule

/* File: dv/acs_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer_tb;
    reg        clk = 1'b0;
    reg        rst_n = 1'b1;
    reg [19:0] addr = 20'h00000;
    reg [7:0]  wdata = 8'h00;
    reg        we = 1'b0;
    reg [2:0]  dsel = 3'h7;
    reg [1:0]  lv = 2'h0;
    reg        en = 1'b0;
    reg        scan = 1'b0;
    reg        rset = 1'b0;
    reg        rclr = 1'b0;
    reg [2:0]  trg = 3'h0;
    wire [7:0] rdata;
    wire [1:0] pref;
    wire       run;
    wire       done;
    wire [1:0] spos;
    wire [3:0] ropt;
    integer    n_fail = 0;
    integer    cmp_count = 0;
    integer    cyc = 0;
    integer    k;
    integer    i;
    integer    nd;

    acs_sequencer dut (
        .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RDATA_O(rdata),
        .CLK_DIV_SEL_I(dsel), .TIMING_MODE_SEL_I(lv), .CONVERTER_ENABLE_I(en), .SCAN_MODE_I(scan),
        .RUN_SET_I(rset), .RUN_CLR_I(rclr), .TIMER_CH1_IRQ_I(trg[0]), .EVENT_LINK_I(trg[1]),
        .INTERVAL_TIMER_IRQ_I(trg[2]), .CONV_RUN_FLAG_O(run), .STAB_WAIT_O(), .CONVERTING_O(),
        .CONV_DONE_O(done), .SCAN_POS_O(spos), .POS_REF_SEL_O(pref), .NEG_REF_SEL_O(ropt[3]),
        .RANGE_CHECK_SEL_O(ropt[2]), .WAKE_CONVERT_ENABLE_O(ropt[1]), .RESOLUTION_SEL_O(ropt[0])
    );

    always #5 clk = ~clk;

    // hang guard, far above the longest expected run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end

    function integer dv(input [2:0] s);
        begin
            dv = (s == 3'h7) ? 2 : s[2] ? 10 - s : 64 >> s;
        end
    endfunction

    task tk(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
                n_fail = n_fail + 1;
            end
        end
    endtask

    task chk_n(input integer got, input integer exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
                n_fail = n_fail + 1;
            end
        end
    endtask

    task wr(input [19:0] a, input [7:0] d);
        begin
            addr = a;
            wdata = d;
            we = 1'b1;
            tk(1);
            we = 1'b0;
            tk(1);
        end
    endtask

    task rd(input [19:0] a, input [7:0] e);
        begin
            addr = a;
            tk(1);
            chk(rdata, e);
        end
    endtask

    task pulse(input [2:0] m);
        begin
            trg = m;
            tk(1);
            trg = 3'h0;
        end
    endtask

    task pr(input s, input c);
        begin
            rset = s;
            rclr = c;
            tk(1);
            rset = 1'b0;
            rclr = 1'b0;
        end
    endtask

    // counts cycles to the next done pulse; a missing pulse fails the flag check
    task wdone(input integer lim);
        begin
            k = 0;
            do begin
                tk(1);
                k = k + 1;
            end while (done !== 1'b1 && k < lim);
            chk({7'h00, done}, 8'h01);
        end
    endtask

    task cfg(input [7:0] tm, input [7:0] ro, input [2:0] s, input [1:0] l);
        begin
            pr(1'b0, 1'b1);
            en = 1'b0;
            tk(1);
            wr(`ACS_TRIG_MODE_ADDR, tm);
            wr(`ACS_REF_OPT_ADDR, ro);
            dsel = s;
            lv = l;
            tk(ro[7] ? 500 : 1);
            en = 1'b1;
            tk(100);
        end
    endtask

    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        rst_n = 1'b0;
        tk(10);
        rst_n = 1'b1;
        tk(3);
        rd(`ACS_TRIG_MODE_ADDR, 8'h00);
        rd(`ACS_REF_OPT_ADDR, 8'h00);
        wr(`ACS_TRIG_MODE_ADDR, 8'hFF);
        wr(`ACS_REF_OPT_ADDR, 8'h7F);
        wr(20'h00000, 8'hFF);
        rd(`ACS_TRIG_MODE_ADDR, 8'hE3);
        rd(`ACS_REF_OPT_ADDR, 8'h6D);
        chk({4'h0, ropt}, 8'h0F);
        rd(20'h00000, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`ACS_REF_OPT_ADDR, {i[1:0], 6'h00});
            chk({6'h00, pref}, {6'h00, i[1:0]});
        end
        // every divider, timing mode and both resolutions in wait mode
        for (i = 0; i < 8; i = i + 1) begin
            cfg(8'hE0, {7'h00, i[2]}, i[2:0], i[1:0]);
            pulse(3'h1);
            wdone(2000);
            nd = (i[1] ? 2 : 8) + 1 + (i[0] ? 17 : 19) - (i[2] ? 2 : 0);
            chk_n(k, dv(i[2:0]) * nd);
            tk(1);
            chk({7'h00, run}, 8'h00);
        end
        for (i = 0; i < 4; i = i + 1) begin
            cfg({6'h38, i[1:0]}, 8'h80, 3'h7, 2'h0);
            pr(1'b1, 1'b0);
            chk({7'h00, run}, 8'h00);
            pulse(i == 3 ? 3'h4 : i == 2 ? 3'h7 : {1'b0, i[0], ~i[0]});
            chk({7'h00, run}, {7'h00, i != 2});
            pr(1'b0, 1'b1);
            if (i == 3) begin
                pulse(3'h4);
                chk({7'h00, run}, 8'h00);
                tk(6);
                pulse(3'h4);
                chk({7'h00, run}, 8'h01);
            end
        end
        // wake bit set: interval guard off, a quick second trigger counts
        cfg(8'hE3, 8'h04, 3'h7, 2'h0);
        pulse(3'h4);
        pr(1'b0, 1'b1);
        pulse(3'h4);
        chk({7'h00, run}, 8'h01);
        cfg(8'h00, 8'h00, 3'h7, 2'h0);
        pr(1'b1, 1'b0);
        wdone(200);
        wdone(200);
        chk_n(k, dv(3'h7) * 19);
        chk({7'h00, run}, 8'h01);
        scan = 1'b1;
        cfg(8'h60, 8'h00, 3'h7, 2'h1);
        pr(1'b1, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            wdone(200);
            chk({6'h00, spos}, {6'h00, i[1:0] + 2'h1});
        end
        chk_n(k, dv(3'h7) * 17);
        tk(2);
        chk({7'h00, run}, 8'h00);
        scan = 1'b0;
        cfg(8'hA0, 8'h00, 3'h7, 2'h0);
        pr(1'b1, 1'b0);
        pulse(3'h1);
        wdone(200);
        tk(2);
        chk({7'h00, run}, 8'h01);
        // second reset in mid-run
        rst_n = 1'b0;
        tk(2);
        rst_n = 1'b1;
        tk(3);
        rd(`ACS_TRIG_MODE_ADDR, 8'h00);
        chk({7'h00, run}, 8'h00);
        end_sim;
    end
endmodule

bind acs_sequencer acs_sequencer_asserts u_chk (
    .CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WE_I, .CLK_DIV_SEL_I, .TIMING_MODE_SEL_I,
    .CONVERTER_ENABLE_I, .SCAN_MODE_I, .RUN_SET_I, .RUN_CLR_I, .TIMER_CH1_IRQ_I, .EVENT_LINK_I,
    .INTERVAL_TIMER_IRQ_I, .CONV_RUN_FLAG_O, .STAB_WAIT_O, .CONVERTING_O, .CONV_DONE_O,
    .POS_REF_SEL_O, .RESOLUTION_SEL_O
);
